// [design/bbas_map.svh]
// Purpose: Register map, field layout, reset values and timing for the billboard sequencer.
// Assumes: 32-bit word-aligned AHB-Lite registers, 200 MHz core clock.
// Notes: Printed offsets are register indices; byte address is four times the index.
`ifndef BBAS_MAP_SVH
`define BBAS_MAP_SVH

`define BBAS_IDX_TA_LOW 16'h413c
`define BBAS_IDX_TA_HIGH 16'h413d
`define BBAS_IDX_TB_LOW 16'h413e
`define BBAS_IDX_TB_HIGH 16'h413f
`define BBAS_IDX_CTRL 16'h4140
`define BBAS_IDX_DESC 16'h4141
`define BBAS_IDX_STATUS 16'h4142
`define BBAS_IDX_MASK 16'h4143
`define BBAS_IDX_STATE 16'h4144

`define BBAS_RST_T_LOW 8'hd0
`define BBAS_RST_T_HIGH 8'h07
`define BBAS_RST_CTRL 8'h14
`define BBAS_RST_CFG_STATUS 2'h0
`define BBAS_RST_ALT_TEXT 8'h02
`define BBAS_RST_INFO_LINK 8'h01

`define BBAS_CTRL_EN 0
`define BBAS_CTRL_SEL_LSB 1
`define BBAS_CTRL_SEL_MSB 5
`define BBAS_DESC_CFG_LSB 0
`define BBAS_DESC_CFG_MSB 1
`define BBAS_DESC_TEXT_LSB 8
`define BBAS_DESC_TEXT_MSB 15
`define BBAS_DESC_LINK_LSB 16
`define BBAS_DESC_LINK_MSB 23

`define BBAS_EV_REQ 0
`define BBAS_EV_TA 1
`define BBAS_EV_TB 2
`define BBAS_EV_STD 3
`define BBAS_EV_W 4

`define BBAS_CLK_MHZ 200
`define BBAS_TICK_MS 10
`define BBAS_TICK_CYCLES (`BBAS_TICK_MS * 1000 * `BBAS_CLK_MHZ)
`define BBAS_DETACH_US 10
`define BBAS_DETACH_CYCLES (`BBAS_DETACH_US * `BBAS_CLK_MHZ)

`endif

// [design/bbas_pkg.sv]
// Purpose: Types shared by the billboard sequencer files.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in bbas_map.svh.
package bbas_pkg;

  typedef enum logic [1:0] {
    BBAS_STD,
    BBAS_DETACH_IN,
    BBAS_BOARD,
    BBAS_DETACH_OUT
  } bbas_state_e;

  typedef logic [15:0] bbas_count_t;

endpackage : bbas_pkg

// [design/bbas_tick_gen.sv]
// Purpose: One-cycle enable pulse every tick period.
// Assumes: Period of at least two cycles.
// Notes: Restarts from zero on clear so the first tick is a whole period away.
`include "bbas_map.svh"

module bbas_tick_gen #(
  parameter int unsigned PERIOD = `BBAS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic clr_i,
  output logic tick_o
);

  logic [31:0] count;
  wire logic at_end = (count == 32'(PERIOD - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i || at_end) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= at_end;
    end
  end

endmodule : bbas_tick_gen

// [design/bbas_hold_timer.sv]
// Purpose: Down-counting billboard hold timer in tick units.
// Assumes: Tick is a one-cycle enable.
// Notes: A load of zero expires on the first tick, the same as a load of one.
module bbas_hold_timer
  import bbas_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic clr_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire bbas_count_t load_i,
  // Status.
  output logic run_o,
  output logic expire_o
);

  bbas_count_t count;
  wire logic last = tick_i && run_o && (count <= 16'h0001);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      run_o <= 1'b0;
      count <= 16'h0000;
    end else if (start_i && !run_o) begin
      run_o <= 1'b1;
      count <= load_i;
    end else if (last) begin
      run_o <= 1'b0;
      count <= 16'h0000;
    end else if (tick_i && run_o) begin
      count <= count - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= last;
    end
  end

endmodule : bbas_hold_timer

// [design/bbas_sequencer.sv]
// Purpose: Billboard attach sequencer with AHB-Lite registers and interrupt.
// Assumes: Request pins and function events are synchronous to clk_i.
// Notes: The slave answers with no wait states; reads return the value before a
// write that is still in its data phase.
//
// The AHB-Lite register port is this design's own decision.
`include "bbas_map.svh"

// Notes on behaviour
// R1 - Low request forces internal function detach first.
// R2 - Then reattach presenting billboard class descriptors.
// R3 - Timer A starts on address assignment.
// R4 - Timer A resets to 07d0h, twenty seconds.
// R5 - Billboard only on failure; status defaults 00b.
// R6 - Alternate text request answered, starts Timer B.
// R7 - Timer B resets to twenty seconds.
// R8 - Either timer expiry forces a detach.
// R9 - Then reattach with standard descriptors.
// R10 - Timers count 16-bit value in 10 ms.
// R11 - Text and link indices are configurable.
// R12 - Five-bit field selects request pin, default 01010.
// R13 - Single enable bit gates the whole feature; here it gates only new requests, not an episode in progress.
// R14 - Partner drives request low on failure.
// R15 - Tick from core clock; timers cleared when detached.
// R16 - New request accepted only in standard personality.
module bbas_sequencer
  import bbas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BBAS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Request pins from the power delivery controller, active low.
  input wire logic [31:0] req_pins_n_i,
  // Events from the internal function.
  input wire logic addr_assigned_i,
  input wire logic alt_text_req_i,
  // Function control.
  output logic func_connect_o,
  output logic board_mode_o,
  output logic alt_text_ack_o,
  output logic [7:0] alt_mode_text_index_o,
  output logic [7:0] info_link_index_o,
  output logic [1:0] mode_config_status_o,
  // Interrupt.
  output logic irq_o
);

  // Word address of a register index.
  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    hit = (addr[31:2] == {14'h0, idx});
  endfunction : hit

  // Software state.
  logic [7:0] ta_low;
  logic [7:0] ta_high;
  logic [7:0] tb_low;
  logic [7:0] tb_high;
  logic [7:0] ctrl;
  logic [1:0] cfg_status;
  logic [7:0] alt_text;
  logic [7:0] info_link;
  logic [`BBAS_EV_W-1:0] status;
  logic [`BBAS_EV_W-1:0] mask;

  // Sequencer state.
  bbas_state_e state;
  bbas_state_e next_state;
  logic [15:0] detach_count;

  // Bus data phase capture.
  logic wr_pend;
  logic [31:0] wr_addr;

  // Address phase decode.
  wire logic addr_phase = hsel_i && htrans_i[1] && hready_i;
  wire logic rd_take = addr_phase && !hwrite_i;
  wire logic wr_take = addr_phase && hwrite_i;

  // Data phase write strobes.
  wire logic we_ta_low = wr_pend && hit(wr_addr, `BBAS_IDX_TA_LOW);
  wire logic we_ta_high = wr_pend && hit(wr_addr, `BBAS_IDX_TA_HIGH);
  wire logic we_tb_low = wr_pend && hit(wr_addr, `BBAS_IDX_TB_LOW);
  wire logic we_tb_high = wr_pend && hit(wr_addr, `BBAS_IDX_TB_HIGH);
  wire logic we_ctrl = wr_pend && hit(wr_addr, `BBAS_IDX_CTRL);
  wire logic we_desc = wr_pend && hit(wr_addr, `BBAS_IDX_DESC);
  wire logic we_status = wr_pend && hit(wr_addr, `BBAS_IDX_STATUS);
  wire logic we_mask = wr_pend && hit(wr_addr, `BBAS_IDX_MASK);

  // Read mux; unmapped addresses read zero.
  wire logic [31:0] rd_ta_low = hit(haddr_i, `BBAS_IDX_TA_LOW) ? {24'h0, ta_low} : 32'h0;
  wire logic [31:0] rd_ta_high = hit(haddr_i, `BBAS_IDX_TA_HIGH) ? {24'h0, ta_high} : 32'h0;
  wire logic [31:0] rd_tb_low = hit(haddr_i, `BBAS_IDX_TB_LOW) ? {24'h0, tb_low} : 32'h0;
  wire logic [31:0] rd_tb_high = hit(haddr_i, `BBAS_IDX_TB_HIGH) ? {24'h0, tb_high} : 32'h0;
  wire logic [31:0] rd_ctrl = hit(haddr_i, `BBAS_IDX_CTRL) ? {24'h0, 2'h0, ctrl[5:0]} : 32'h0;
  wire logic [31:0] rd_desc = hit(haddr_i, `BBAS_IDX_DESC) ?
      {8'h0, info_link, alt_text, 6'h0, cfg_status} : 32'h0;
  wire logic [31:0] rd_status = hit(haddr_i, `BBAS_IDX_STATUS) ?
      {28'h0, status} : 32'h0;
  wire logic [31:0] rd_mask = hit(haddr_i, `BBAS_IDX_MASK) ? {28'h0, mask} : 32'h0;
  wire logic run_a;
  wire logic run_b;
  wire logic [31:0] rd_state = hit(haddr_i, `BBAS_IDX_STATE) ?
      {28'h0, run_b, run_a, 2'(state)} : 32'h0;
  wire logic [31:0] rd_data = rd_ta_low | rd_ta_high | rd_tb_low | rd_tb_high |
      rd_ctrl | rd_desc | rd_status | rd_mask | rd_state;

  // Request pin selection and acceptance.
  wire logic feat_en = ctrl[`BBAS_CTRL_EN]; // R13
  wire logic [4:0] pin_sel = ctrl[`BBAS_CTRL_SEL_MSB:`BBAS_CTRL_SEL_LSB]; // R12
  wire logic req_low = !req_pins_n_i[pin_sel]; // R14
  wire logic req_take = feat_en && req_low && (state == BBAS_STD); // R16

  // Timer wiring.
  wire logic tick;
  wire logic exp_a;
  wire logic exp_b;
  wire logic timers_clr = (state != BBAS_BOARD); // R15
  wire logic start_a = (state == BBAS_BOARD) && addr_assigned_i; // R3
  wire logic start_b = (state == BBAS_BOARD) && alt_text_req_i; // R6
  wire logic any_exp = exp_a || exp_b; // R8
  wire logic detach_done = (detach_count == 16'(`BBAS_DETACH_CYCLES - 1));
  wire logic in_detach = (state == BBAS_DETACH_IN) || (state == BBAS_DETACH_OUT);

  // Interrupt events, one cycle each.
  wire logic [`BBAS_EV_W-1:0] events = {
    (state == BBAS_DETACH_OUT) && detach_done,
    exp_b && (state == BBAS_BOARD),
    exp_a && (state == BBAS_BOARD),
    req_take
  };

  // Next levels of the registered outputs; every output comes straight from a
  // flip-flop so the function never sees a decode glitch.
  wire logic next_func_connect = (next_state == BBAS_STD) || (next_state == BBAS_BOARD);
  wire logic next_board_mode = (next_state == BBAS_BOARD);
  wire logic [`BBAS_EV_W-1:0] status_clr = we_status ? hwdata_i[`BBAS_EV_W-1:0] : '0;
  wire logic [`BBAS_EV_W-1:0] next_status = (status & ~status_clr) | events;
  wire logic next_irq = |(status & mask);

  // The tick restarts on entry to the billboard personality, so a timer never
  // sees a partial first period left over from an earlier episode.
  bbas_tick_gen #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(timers_clr),
    .tick_o(tick)
  ); // R15

  bbas_hold_timer u_timer_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(timers_clr),
    .start_i(start_a),
    .tick_i(tick),
    .load_i({ta_high, ta_low}),
    .run_o(run_a),
    .expire_o(exp_a)
  ); // R10

  bbas_hold_timer u_timer_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(timers_clr),
    .start_i(start_b),
    .tick_i(tick),
    .load_i({tb_high, tb_low}),
    .run_o(run_b),
    .expire_o(exp_b)
  ); // R10

  // Next state of the personality sequence.
  always_comb begin
    next_state = state;
    case (state)
      BBAS_STD: begin
        if (req_take) begin
          next_state = BBAS_DETACH_IN; // R1
        end
      end
      BBAS_DETACH_IN: begin
        if (detach_done) begin
          next_state = BBAS_BOARD; // R2
        end
      end
      BBAS_BOARD: begin
        if (any_exp) begin
          next_state = BBAS_DETACH_OUT; // R8
        end
      end
      BBAS_DETACH_OUT: begin
        if (detach_done) begin
          next_state = BBAS_STD; // R9
        end
      end
      default: begin
        next_state = BBAS_STD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= BBAS_STD;
    end else begin
      state <= next_state;
    end
  end

  // Detach hold time, long enough for the hub port to see a disconnect.
  always_ff @(posedge clk_i) begin
    if (rst_i || (state != next_state)) begin
      detach_count <= 16'h0000;
    end else if (in_detach) begin
      detach_count <= detach_count + 16'h0001;
    end
  end

  // Function control outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_connect_o <= 1'b1;
      board_mode_o <= 1'b0;
      alt_text_ack_o <= 1'b0;
    end else begin
      func_connect_o <= next_func_connect; // R1
      board_mode_o <= next_board_mode; // R2
      alt_text_ack_o <= start_b; // R6
    end
  end

  // Descriptor fields handed to the function.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_mode_text_index_o <= `BBAS_RST_ALT_TEXT;
      info_link_index_o <= `BBAS_RST_INFO_LINK;
      mode_config_status_o <= `BBAS_RST_CFG_STATUS;
    end else begin
      alt_mode_text_index_o <= alt_text; // R11
      info_link_index_o <= info_link; // R11
      mode_config_status_o <= cfg_status; // R5
    end
  end

  // Bus slave: zero wait states, always OKAY. Read data is taken in the address
  // phase, so a read right behind a write still sees the old register value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend <= wr_take;
      if (wr_take) begin
        wr_addr <= haddr_i;
      end
      if (rd_take) begin
        hrdata_o <= rd_data;
      end
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Timer registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ta_low <= `BBAS_RST_T_LOW; // R4
      ta_high <= `BBAS_RST_T_HIGH; // R4
      tb_low <= `BBAS_RST_T_LOW; // R7
      tb_high <= `BBAS_RST_T_HIGH; // R7
    end else begin
      if (we_ta_low) begin
        ta_low <= hwdata_i[7:0];
      end
      if (we_ta_high) begin
        ta_high <= hwdata_i[7:0];
      end
      if (we_tb_low) begin
        tb_low <= hwdata_i[7:0];
      end
      if (we_tb_high) begin
        tb_high <= hwdata_i[7:0];
      end
    end
  end

  // Feature control and descriptor configuration.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `BBAS_RST_CTRL; // R12
      cfg_status <= `BBAS_RST_CFG_STATUS; // R5
      alt_text <= `BBAS_RST_ALT_TEXT;
      info_link <= `BBAS_RST_INFO_LINK;
    end else begin
      if (we_ctrl) begin
        ctrl <= {2'h0, hwdata_i[5:0]}; // R13
      end
      if (we_desc) begin
        cfg_status <= hwdata_i[`BBAS_DESC_CFG_MSB:`BBAS_DESC_CFG_LSB];
        alt_text <= hwdata_i[`BBAS_DESC_TEXT_MSB:`BBAS_DESC_TEXT_LSB]; // R11
        info_link <= hwdata_i[`BBAS_DESC_LINK_MSB:`BBAS_DESC_LINK_LSB]; // R11
      end
    end
  end

  // Sticky status: an event in the clearing cycle survives the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      if (we_mask) begin
        mask <= hwdata_i[`BBAS_EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

endmodule : bbas_sequencer

// [dv/bbas_sequencer_monitor.sv]
// Purpose: Port assertions for the billboard sequencer.
// Assumes: Inputs change just after rising edges of clk_i.
// Notes: Enable and pin select are mirrored from bus writes to the control word.
`include "bbas_map.svh"
module bbas_sequencer_monitor #(
  parameter int unsigned TICK_CYCLES = 20
) (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  // Pins and function.
  input wire logic [31:0] req_pins_n_i,
  input wire logic addr_assigned_i,
  input wire logic alt_text_req_i,
  input wire logic func_connect_o,
  input wire logic board_mode_o,
  input wire logic alt_text_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ctrl;
  logic en;
  logic [4:0] sel;
  logic started;
  logic going_in;
  int unsigned low_cnt;
  int unsigned live_cnt;
  wire live = func_connect_o && board_mode_o;
  wire idle = func_connect_o && !board_mode_o;
  wire pin_low = !req_pins_n_i[sel];
  wire ev = addr_assigned_i || alt_text_req_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ctrl <= 1'b0;
      en <= 1'b0;
      sel <= 5'h0a;
      started <= 1'b0;
      going_in <= 1'b0;
      low_cnt <= 0;
      live_cnt <= 0;
    end else begin
      wr_ctrl <= hsel_i && htrans_i[1] && hready_i && hwrite_i
        && haddr_i[31:2] == 30'(`BBAS_IDX_CTRL);
      if (wr_ctrl) begin
        en <= hwdata_i[0];
        sel <= hwdata_i[5:1];
      end
      if (func_connect_o) begin
        going_in <= !board_mode_o;
      end
      started <= board_mode_o && (started || (live && ev));
      low_cnt <= func_connect_o ? 0 : low_cnt + 1;
      live_cnt <= live ? live_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  accept_a: assert property (en && idle && pin_low |=> !func_connect_o)
    else $error("request not taken");
  gate_a: assert property (!en && idle |=> func_connect_o)
    else $error("request taken while disabled");
  hold_a: assert property ($rose(func_connect_o) |-> low_cnt == `BBAS_DETACH_CYCLES)
    else $error("detach hold length wrong");
  mode_a: assert property ($changed(board_mode_o) |-> $changed(func_connect_o))
    else $error("descriptors changed while attached");
  reattach_a: assert property ($rose(func_connect_o) |-> board_mode_o == going_in)
    else $error("reattached with wrong descriptors");
  ack_a: assert property (live && alt_text_req_i |=> alt_text_ack_o)
    else $error("text request not answered");
  ack_cause_a: assert property (alt_text_ack_o |-> $past(live && alt_text_req_i))
    else $error("text answer without request");
  expire_a: assert property ($fell(board_mode_o) |-> started && live_cnt + 1 >= TICK_CYCLES)
    else $error("billboard left without expiry");
  stay_a: assert property (live && !started |=> board_mode_o)
    else $error("billboard left with no timer");
endmodule : bbas_sequencer_monitor

// [dv/bbas_pd_host_model.sv]
// Purpose: Stand-in for the power delivery controller and the host.
// Assumes: Tasks are called right after a rising edge.
// Notes: Released request pins read high, as if pulled up.
module bbas_pd_host_model (
  // Clock.
  input wire logic clk_i,
  // Request pins and host events.
  output logic [31:0] req_pins_n_o,
  output logic addr_assigned_o,
  output logic alt_text_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_pins_n_o = 32'hffff_ffff;
    addr_assigned_o = 1'b0;
    alt_text_req_o = 1'b0;
  end
  task automatic fail(input logic [4:0] pin);
    req_pins_n_o[pin] <= 1'b0;
  endtask : fail
  task automatic recover();
    req_pins_n_o <= 32'hffff_ffff;
  endtask : recover
  task automatic host_event(input logic text);
    addr_assigned_o <= !text;
    alt_text_req_o <= text;
    @(posedge clk_i);
    addr_assigned_o <= 1'b0;
    alt_text_req_o <= 1'b0;
    @(posedge clk_i);
  endtask : host_event
endmodule : bbas_pd_host_model

// [dv/bbas_sequencer_tb_top.sv]
// Purpose: Self-checking bench for the billboard sequencer.
// Assumes: Tick shortened to TICK cycles; detach hold is the fixed design value.
// Notes: Timer bounds allow for the free-running tick phase.
`include "bbas_map.svh"
module bbas_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic conn;
  logic board;
  logic ack;
  logic irq;
  logic resp;
  logic [7:0] txt;
  logic [7:0] lnk;
  logic [1:0] cfg;
  wire [31:0] pins;
  wire addr_ev;
  wire text_ev;
  int n_fail = 0;
  int num_checks = 0;
  int n_ack = 0;
  logic [31:0] rst_exp [10] = '{32'hd0, 32'h7, 32'hd0, 32'h7, 32'h14, 32'h10200,
    32'h0, 32'h0, 32'h0, 32'h0};
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (ack === 1'b1) n_ack++;
  bbas_pd_host_model pd (.clk_i(clk_i), .req_pins_n_o(pins), .addr_assigned_o(addr_ev),
    .alt_text_req_o(text_ev));
  bbas_sequencer #(.TICK_CYCLES(TICK)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(resp), .req_pins_n_i(pins),
    .addr_assigned_i(addr_ev), .alt_text_req_i(text_ev), .func_connect_o(conn),
    .board_mode_o(board), .alt_text_ack_o(ack), .alt_mode_text_index_o(txt),
    .info_link_index_o(lnk), .mode_config_status_o(cfg), .irq_o(irq));
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ready();
    do begin
      @(posedge clk_i);
    end while (hready !== 1'b1);
  endtask : ready
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask : wr
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask : rdchk
  task automatic await(input logic c, input logic b, output int n);
    for (n = 0; n < 9000; n++) begin
      @(negedge clk_i);
      if (conn === c && board === b) break;
    end
    if (n >= 9000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: wait limit reached", $time);
    end
    @(posedge clk_i);
  endtask : await
  initial begin
    logic [31:0] d;
    logic [4:0] sel;
    logic [7:0] ta;
    logic [7:0] tb;
    int n;
    d = $urandom(32'h478d);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({10'h0, resp, txt, lnk, cfg, conn, board, irq},
      {10'h0, 1'b0, 8'h2, 8'h1, 2'h0, 3'h4});
    for (int k = 0; k < 10; k++) begin
      rdchk(16'h413c + 16'(k), rst_exp[k]);
    end
    d = $urandom & 32'h00ff_ff03;
    wr(`BBAS_IDX_DESC, d);
    rdchk(`BBAS_IDX_DESC, d);
    chk({8'h0, lnk, txt, 6'h0, cfg}, d);
    sel = 5'($urandom);
    ta = 8'($urandom_range(5, 2));
    tb = 8'($urandom_range(5, 2));
    wr(`BBAS_IDX_TA_LOW, {24'h0, ta});
    wr(`BBAS_IDX_TA_HIGH, 32'h0);
    wr(`BBAS_IDX_TB_LOW, {24'h0, tb});
    wr(`BBAS_IDX_TB_HIGH, 32'h1);
    wr(`BBAS_IDX_MASK, 32'hf);
    wr(`BBAS_IDX_CTRL, {26'h0, sel, 1'b0});
    pd.fail(sel);
    repeat (40) @(posedge clk_i);
    chk(32'(conn), 32'h1);
    wr(`BBAS_IDX_CTRL, {26'h0, sel, 1'b1});
    await(1'b0, 1'b0, n);
    chk(32'(n < 4), 32'h1);
    rdchk(`BBAS_IDX_STATUS, 32'h1);
    chk(32'(irq), 32'h1);
    await(1'b1, 1'b1, n);
    chk(32'(n > 1990), 32'h1);
    repeat (4 * TICK) @(posedge clk_i);
    chk({30'h0, conn, board}, 32'h3);
    pd.recover();
    wr(`BBAS_IDX_STATUS, 32'h1);
    rdchk(`BBAS_IDX_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    pd.host_event(1'b0);
    pd.host_event(1'b1);
    await(1'b0, 1'b0, n);
    chk(32'(n <= ta * TICK + 4 && n + TICK + 4 >= ta * TICK), 32'h1);
    rdchk(`BBAS_IDX_STATE, 32'h3);
    await(1'b1, 1'b0, n);
    rdchk(`BBAS_IDX_STATUS, 32'ha);
    wr(`BBAS_IDX_STATUS, 32'hf);
    wr(`BBAS_IDX_MASK, 32'h0);
    pd.fail(sel);
    await(1'b1, 1'b1, n);
    pd.recover();
    pd.host_event(1'b1);
    await(1'b0, 1'b0, n);
    chk(32'(n_ack), 32'h2);
    chk(32'(n <= (256 + tb) * TICK + 4 && n + TICK + 4 >= (256 + tb) * TICK), 32'h1);
    chk(32'(irq), 32'h0);
    wr(`BBAS_IDX_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    await(1'b1, 1'b0, n);
    rdchk(`BBAS_IDX_STATUS, 32'hd);
    close_out();
  end
  initial begin
    #400us;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : bbas_sequencer_tb_top
bind bbas_sequencer bbas_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .req_pins_n_i(req_pins_n_i), .addr_assigned_i(addr_assigned_i),
  .alt_text_req_i(alt_text_req_i), .func_connect_o(func_connect_o),
  .board_mode_o(board_mode_o), .alt_text_ack_o(alt_text_ack_o));
